/* File: hw/ufh_port.sv */
// Parallel FIFO port of the USB bridge with AHB-Lite control registers
//
// Contract
// - Writer writes only while transmit_not_ready_n is low; it rises after each write and stays high while full or storing.
// - receive_empty_n is low whenever a received byte waits and the read strobe is high, outside bit-bang mode.
// - Reader reads one byte per low receive_empty_n; it rises after each read and falls only with another byte.
// - Receive buffer holds 128 bytes and transmit buffer 384 bytes.
// - In suspend with remote wakeup enabled, a low strobe on send_now_wake_n requests resume.
// - Outside suspend a low strobe on send_now_wake_n sends buffered data at the next IN request, short or not.
// - Flush timeout is programmable 1 to 255 ms in 1 ms steps, default 16 ms.
// - power_on_n is high while suspended.
// - With the option set, FIFO lines are weakly pulled low while power_on_n is high.
// - Bit-bang mode turns the data lines into an 8-bit output port, driven bit by bit as bbdir_r enables, and FIFO mode can return.
// - In bit-bang mode received bytes are put out one by one, paced by a prescaled timer.
// - Baud rate commands have no effect.
// - An option bit selects isochronous instead of bulk transfers.
// - Data is driven while the read strobe is low; the next byte is fetched at its rising edge.
// - The data byte is stored at the falling edge of the write strobe.
// - The port logic runs on one internal reference clock.
`timescale 1ns/1ps
module ufh_port (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [7:0] i_data,
	input wire logic i_rd_n,
	input wire logic i_wr,
	input wire logic i_send_now_wake_n,
	output ufh_pkg::ufh_bus_type o_bus,
	output logic o_transmit_not_ready_n,
	output logic o_receive_empty_n,
	output logic o_power_on_n,
	output logic o_resume_req,
	output logic o_send_now,
	output logic o_flush,
	output logic o_iso_mode
);
	// Pin synchronisers: stage one feeds stage two only
	logic [7:0] d_s1_r, d_s2_r;
	logic [2:0] c_s1_r, c_s2_r, c_prev_r;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			d_s1_r <= 8'h00;
			d_s2_r <= 8'h00;
			c_s1_r <= 3'h5;
			c_s2_r <= 3'h5;
			c_prev_r <= 3'h5;
		end else begin
			d_s1_r <= i_data;
			d_s2_r <= d_s1_r;
			c_s1_r <= {i_send_now_wake_n, i_wr, i_rd_n};
			c_s2_r <= c_s1_r;
			c_prev_r <= c_s2_r;
		end
	end
	logic rd_low, rd_rise, wr_fall, snw_fall;
	assign rd_low = !c_s2_r[0];
	assign rd_rise = c_s2_r[0] && !c_prev_r[0];
	assign wr_fall = !c_s2_r[1] && c_prev_r[1];
	assign snw_fall = !c_s2_r[2] && c_prev_r[2];

	// Registers
	logic [7:0] ctrl_r, tout_r, bbdir_r, baud_r;
	logic [15:0] bbdiv_r;
	logic ph_wr_r, ph_rd_r;
	logic [7:0] ph_addr_r;
	logic addr_ok;
	assign addr_ok = i_hsel && i_hready && i_htrans == ufh_pkg::HTRANS_NONSEQ;

	// Address phase capture; slave is always ready, response OKAY
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ph_wr_r <= 1'b0;
			ph_rd_r <= 1'b0;
			ph_addr_r <= 8'h00;
		end else begin
			ph_wr_r <= addr_ok && i_hwrite;
			ph_rd_r <= addr_ok && !i_hwrite;
			ph_addr_r <= i_haddr[7:0];
		end
	end
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	logic w_ctrl, w_tout, w_bbdiv, w_baud, w_rxpush, w_txpop, w_bbdir;
	assign w_ctrl = ph_wr_r && ph_addr_r == ufh_pkg::A_CTRL;
	assign w_tout = ph_wr_r && ph_addr_r == ufh_pkg::A_TOUT;
	assign w_bbdiv = ph_wr_r && ph_addr_r == ufh_pkg::A_BBDIV;
	assign w_baud = ph_wr_r && ph_addr_r == ufh_pkg::A_BAUD;
	assign w_rxpush = ph_wr_r && ph_addr_r == ufh_pkg::A_RXPUSH;
	assign w_txpop = ph_rd_r && ph_addr_r == ufh_pkg::A_TXPOP;
	assign w_bbdir = ph_wr_r && ph_addr_r == ufh_pkg::A_BBDIR;

	// Host-command registers; a zero timeout write is ignored, keeping the old value
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_r <= 8'h00;
			tout_r <= ufh_pkg::TOUT_RST;
			bbdiv_r <= ufh_pkg::BBDIV_RST;
			bbdir_r <= 8'h00;
			baud_r <= 8'h00;
		end else begin
			if (w_ctrl) ctrl_r <= i_hwdata[7:0];
			if (w_tout && i_hwdata[7:0] != 8'h00) begin
				tout_r <= i_hwdata[7:0];
			end
			if (w_bbdiv) bbdiv_r <= i_hwdata[15:0];
			if (w_bbdir) bbdir_r <= i_hwdata[7:0];
			// Stored for readback only, steers nothing
			if (w_baud) baud_r <= i_hwdata[7:0];
		end
	end
	logic susp, bb_mode;
	assign susp = ctrl_r[ufh_pkg::C_SUSP];
	assign bb_mode = ctrl_r[ufh_pkg::C_BB];

	// Buffers: receive 128, transmit 384
	logic [7:0] rx_q, tx_q;
	logic [ufh_pkg::RX_CW-1:0] rx_cnt;
	logic [ufh_pkg::TX_CW-1:0] tx_cnt;
	logic rx_pop, tx_push, tx_pop, bb_pop;
	ufh_fifo #(.DEPTH(ufh_pkg::RX_DEPTH), .AW(ufh_pkg::RX_AW),
		.CW(ufh_pkg::RX_CW)) u_rx (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_push(w_rxpush),
		.i_data(i_hwdata[7:0]),
		.i_pop(rx_pop),
		.o_data(rx_q),
		.o_count(rx_cnt)
	);
	ufh_fifo #(.DEPTH(ufh_pkg::TX_DEPTH), .AW(ufh_pkg::TX_AW),
		.CW(ufh_pkg::TX_CW)) u_tx (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_push(tx_push),
		.i_data(d_s2_r),
		.i_pop(tx_pop),
		.o_data(tx_q),
		.o_count(tx_cnt)
	);
	localparam logic [ufh_pkg::TX_CW-1:0] TX_FULL =
		ufh_pkg::TX_CW'(ufh_pkg::TX_DEPTH);
	assign tx_pop = w_txpop;

	// Write strobe falling edge stores the byte
	assign tx_push = wr_fall && !bb_mode && !o_transmit_not_ready_n;
	// Rising edge of read strobe consumes the shown byte
	assign rx_pop = (rd_rise && !bb_mode && !o_receive_empty_n) || bb_pop;

	// Transmit ready flag: high after each write, while full or in bit-bang
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_transmit_not_ready_n <= 1'b1;
		end else begin
			// Full means every one of the 384 places is taken
			o_transmit_not_ready_n <= tx_push || bb_mode ||
				tx_cnt == TX_FULL;
		end
	end

	// Receive flag rises on each read, falls only while data waits and
	// the strobe is back high, so one low phase means exactly one byte
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_receive_empty_n <= 1'b1;
		end else if (rx_pop || bb_mode) begin
			o_receive_empty_n <= 1'b1;
		end else if (rx_cnt != '0 && !rd_low) begin
			o_receive_empty_n <= 1'b0;
		end
	end

	// Bit-bang pacing timer
	logic [15:0] bb_cnt_r;
	logic bb_tick;
	assign bb_tick = bb_cnt_r == 16'h0000;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			bb_cnt_r <= 16'h0000;
		end else if (!bb_mode || bb_tick) begin
			bb_cnt_r <= bbdiv_r;
		end else begin
			bb_cnt_r <= bb_cnt_r - 16'h0001;
		end
	end
	assign bb_pop = bb_mode && bb_tick && rx_cnt != '0;

	// Data bus drive and weak pull-down
	logic [7:0] bb_out_r;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			bb_out_r <= 8'h00;
			o_bus <= '{dout: 8'h00, doe_n: 8'hFF, pull_dn: 8'h00};
		end else begin
			if (bb_pop) bb_out_r <= rx_q;
			if (bb_mode) begin
				o_bus.dout <= bb_pop ? rx_q : bb_out_r;
				o_bus.doe_n <= ~bbdir_r;
			end else begin
				o_bus.dout <= rx_q;
				// Released on the third clock edge after the pin rises, slight overlap ok
				o_bus.doe_n <= {8{!(rd_low && !o_receive_empty_n)}};
			end
			o_bus.pull_dn <= {8{ctrl_r[ufh_pkg::C_PDEN] && susp}};
		end
	end

	// Suspend power, wakeup and send-now
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_power_on_n <= 1'b1;
			o_resume_req <= 1'b0;
			o_send_now <= 1'b0;
			o_iso_mode <= 1'b0;
		end else begin
			o_power_on_n <= susp;
			o_iso_mode <= ctrl_r[ufh_pkg::C_ISO];
			o_resume_req <= snw_fall && susp &&
				ctrl_r[ufh_pkg::C_RWEN];
			// Set wins over the clear by the IN request
			if (snw_fall && !susp) begin
				o_send_now <= 1'b1;
			end else if (ctrl_r[ufh_pkg::C_INREQ] || tx_cnt == '0) begin
				o_send_now <= 1'b0;
			end
		end
	end

	// Flush timer: 1 ms tick, restarts whenever a byte is written
	logic [15:0] ms_cnt_r;
	logic [7:0] tmo_r;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ms_cnt_r <= 16'h0000;
			tmo_r <= 8'h00;
			o_flush <= 1'b0;
		end else begin
			o_flush <= 1'b0;
			if (tx_push || tx_cnt == '0) begin
				ms_cnt_r <= 16'h0000;
				tmo_r <= 8'h00;
			end else if (ms_cnt_r ==
				16'(ufh_pkg::TICK_MS_CYC - 1)) begin
				ms_cnt_r <= 16'h0000;
				if (tmo_r + 8'h01 == tout_r) begin
					tmo_r <= 8'h00;
					o_flush <= 1'b1;
				end else begin
					tmo_r <= tmo_r + 8'h01;
				end
			end else begin
				ms_cnt_r <= ms_cnt_r + 16'h0001;
			end
		end
	end

	// Read data, registered
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_hrdata <= 32'h0000_0000;
		end else if (addr_ok && !i_hwrite) begin
			unique case (i_haddr[7:0])
				ufh_pkg::A_CTRL: o_hrdata <= {24'h0, ctrl_r};
				ufh_pkg::A_STAT: o_hrdata <= {6'h0, tx_cnt, 8'h0, rx_cnt};
				ufh_pkg::A_TOUT: o_hrdata <= {24'h0, tout_r};
				ufh_pkg::A_BBDIV: o_hrdata <= {16'h0, bbdiv_r};
				ufh_pkg::A_BAUD: o_hrdata <= {24'h0, baud_r};
				ufh_pkg::A_TXPOP: o_hrdata <= {23'h0, tx_cnt != '0, tx_q};
				ufh_pkg::A_BBDIR: o_hrdata <= {24'h0, bbdir_r};
				default: o_hrdata <= 32'h0000_0000;
			endcase
		end
	end
	// The 40 MHz clock stands in for the internal reference clock
endmodule // ufh_port

/* File: hw/ufh_pkg.sv */
// Package for the byte-wide FIFO port: constants and carrier structs
package ufh_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_MS_CYC = CLK_HZ / MS_PER_S;
	localparam int unsigned RX_DEPTH = 128;
	localparam int unsigned TX_DEPTH = 384;
	localparam int unsigned RX_AW = 7;
	localparam int unsigned TX_AW = 9;
	localparam int unsigned TX_CW = 10;
	localparam int unsigned RX_CW = 8;
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TOUT = 8'h08;
	localparam logic [7:0] A_BBDIV = 8'h0C;
	localparam logic [7:0] A_BAUD = 8'h10;
	localparam logic [7:0] A_RXPUSH = 8'h14;
	localparam logic [7:0] A_TXPOP = 8'h18;
	localparam logic [7:0] A_BBDIR = 8'h1C;
	// Control register fields
	localparam int unsigned C_SUSP = 0;
	localparam int unsigned C_RWEN = 1;
	localparam int unsigned C_PDEN = 2;
	localparam int unsigned C_ISO = 3;
	localparam int unsigned C_BB = 4;
	localparam int unsigned C_INREQ = 5;
	localparam logic [7:0] TOUT_RST = 8'h10;
	localparam logic [15:0] BBDIV_RST = 16'h0001;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] doe_n;
		logic [7:0] pull_dn;
	} ufh_bus_type;
endpackage

/* File: hw/ufh_fifo.sv */
// Synchronous byte FIFO with honest counts
`timescale 1ns/1ps
module ufh_fifo #(
	parameter int unsigned DEPTH = 4,
	parameter int unsigned AW = 2,
	parameter int unsigned CW = 3
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_push,
	input wire logic [7:0] i_data,
	input wire logic i_pop,
	output logic [7:0] o_data,
	output logic [CW-1:0] o_count
);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic do_push;
	logic do_pop;
	assign do_push = i_push && (o_count != FULLC);
	assign do_pop = i_pop && (o_count != '0);
	assign o_data = mem[rp_r];
	// Storage has no reset, only pointers and count do
	always_ff @(posedge i_clk_sys) begin
		if (do_push) begin
			mem[wp_r] <= i_data;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			o_count <= '0;
		end else begin
			if (do_push) begin
				wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
			end
			if (do_pop) begin
				rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
			end
			o_count <= o_count + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule // ufh_fifo

/* File: sim/ufh_port_monitor.sv */
// Checker of the FIFO port flags, bus drive and mode outputs
`timescale 1ns/1ps
module ufh_port_monitor (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic i_rd_n,
	input wire logic i_wr,
	input wire ufh_pkg::ufh_bus_type o_bus,
	input wire logic o_transmit_not_ready_n,
	input wire logic o_receive_empty_n,
	input wire logic o_power_on_n,
	input wire logic o_resume_req,
	input wire logic o_iso_mode
);
	logic ph_r;
	logic [5:0] ctl_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Shadow of the control word, so mode-bound checks know the mode
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ph_r <= 1'h0;
			ctl_r <= 6'h00;
		end else begin
			ph_r <= i_hsel && i_hready && i_hwrite && i_haddr[7:0] == 8'h00
				&& i_htrans == ufh_pkg::HTRANS_NONSEQ;
			if (ph_r) ctl_r <= i_hwdata[5:0];
		end
	end
	wr_flag_a: assert property (
		$fell(i_wr) && !o_transmit_not_ready_n |-> ##[1:6]
		o_transmit_not_ready_n) else $error("tx flag did not rise");
	rd_flag_a: assert property (
		$rose(i_rd_n) && !o_receive_empty_n && !ctl_r[4] |-> ##[1:6]
		o_receive_empty_n) else $error("rx flag did not rise");
	bus_drive_a: assert property (
		$fell(i_rd_n) && !o_receive_empty_n && !ctl_r[4] |-> ##[1:5]
		o_bus.doe_n == 8'h00) else $error("read byte not driven");
	bus_release_a: assert property (
		(!ctl_r[4] && i_rd_n) [*6] |-> o_bus.doe_n == 8'hFF)
		else $error("bus driven outside read");
	suspend_power_a: assert property (
		ctl_r[0] [*3] |-> o_power_on_n) else $error("power not off");
	pull_on_a: assert property (
		(ctl_r[2] && o_power_on_n) [*3] |-> o_bus.pull_dn == 8'hFF)
		else $error("pull-down missing");
	pull_off_a: assert property (
		!o_power_on_n [*3] |-> o_bus.pull_dn == 8'h00)
		else $error("pull-down while powered");
	iso_mode_a: assert property (
		$stable(ctl_r[3]) [*3] |-> o_iso_mode == ctl_r[3])
		else $error("iso mode wrong");
	wake_cond_a: assert property (
		o_resume_req |-> o_power_on_n && ctl_r[1])
		else $error("resume outside suspend");
	bb_flags_a: assert property (
		ctl_r[4] [*2] |-> o_transmit_not_ready_n && o_receive_empty_n)
		else $error("flags low in bit-bang");
endmodule // ufh_port_monitor

bind ufh_port ufh_port_monitor i_mon (
	.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_hsel(i_hsel),
	.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
	.i_hwdata(i_hwdata), .i_hready(i_hready), .i_rd_n(i_rd_n),
	.i_wr(i_wr), .o_bus(o_bus), .o_receive_empty_n(o_receive_empty_n),
	.o_transmit_not_ready_n(o_transmit_not_ready_n),
	.o_power_on_n(o_power_on_n), .o_resume_req(o_resume_req),
	.o_iso_mode(o_iso_mode)
);

/* File: sim/ufh_mcu_model.sv */
// Far-side logic model on the byte-wide FIFO handshake
`timescale 1ns/1ps
module ufh_mcu_model (
	input wire logic i_clk_sys,
	input wire ufh_pkg::ufh_bus_type i_bus,
	input wire logic i_txnr_n,
	input wire logic i_rxe_n,
	output logic [7:0] o_data,
	output logic o_rd_n,
	output logic o_wr
);
	logic [7:0] drv_r = 8'h00;
	logic drv_en = 1'h0;
	logic [7:0] last_r = 8'h00;
	initial begin
		o_rd_n = 1'h1;
		o_wr = 1'h0;
	end
	// Floating bus toggles each cycle unless pulled down, so a stale byte never passes
	assign o_data = (~i_bus.doe_n & i_bus.dout) | (i_bus.doe_n
		& (drv_en ? drv_r : ~last_r & ~i_bus.pull_dn));
	always_ff @(posedge i_clk_sys) last_r <= o_data;
	// Write only while ready; data stands across the falling strobe
	task automatic wr_byte(input logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (i_txnr_n !== 1'h0 && n < 200) begin
			@(posedge i_clk_sys);
			n++;
		end
		ok = (n < 200);
		if (ok) begin
			drv_r <= b;
			drv_en <= 1'h1;
			o_wr <= 1'h1;
			repeat (4) @(posedge i_clk_sys);
			o_wr <= 1'h0;
			repeat (4) @(posedge i_clk_sys);
			drv_en <= 1'h0;
			@(posedge i_clk_sys);
		end
	endtask
	// One read per low flag; byte taken while the strobe is low
	task automatic rd_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (i_rxe_n !== 1'h0 && n < 200) begin
			@(posedge i_clk_sys);
			n++;
		end
		ok = (n < 200);
		if (ok) begin
			o_rd_n <= 1'h0;
			repeat (5) @(posedge i_clk_sys);
			b = o_data;
			o_rd_n <= 1'h1;
			repeat (5) @(posedge i_clk_sys);
		end
	endtask
endmodule // ufh_mcu_model

/* File: sim/ufh_port_tb_top.sv */
// Self-checking bench of the FIFO port with its far-side model
`timescale 1ns/1ps
module ufh_port_tb_top;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic wake_n = 1'h1;
	logic [31:0] hrdata;
	logic hready, hresp, rd_n, wr, txnr_n, rxe_n, pwr_n;
	logic resume, send_now, flush, iso;
	logic [7:0] data;
	ufh_pkg::ufh_bus_type bus;
	int failures = 0;
	int comparisons = 0;
	always #12.5 clk = ~clk;
	ufh_port i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_data(data), .i_rd_n(rd_n), .i_wr(wr),
		.i_send_now_wake_n(wake_n), .o_bus(bus),
		.o_transmit_not_ready_n(txnr_n), .o_receive_empty_n(rxe_n),
		.o_power_on_n(pwr_n), .o_resume_req(resume),
		.o_send_now(send_now), .o_flush(flush), .o_iso_mode(iso));
	ufh_mcu_model i_mcu (.i_clk_sys(clk), .i_bus(bus), .i_txnr_n(txnr_n),
		.i_rxe_n(rxe_n), .o_data(data), .o_rd_n(rd_n), .o_wr(wr));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Single AHB transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		htrans <= ufh_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		r = hrdata;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'h1, a, d, r);
	endtask
	// Strobe the wake pin low and note which reaction followed
	task automatic strobe(output logic res, output logic snd);
		res = 1'h0;
		snd = 1'h0;
		wake_n <= 1'h0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			if (k == 4) wake_n <= 1'h1;
			res |= (resume === 1'h1);
			snd |= (send_now === 1'h1);
		end
	endtask
	task automatic t_reset();
		logic [31:0] r;
		ahb(1'h0, ufh_pkg::A_TOUT, 32'h0, r);
		chk(r, 32'h10);
		chk(txnr_n, 1'h0);
		chk(pwr_n, 1'h0);
		chk(bus.doe_n, 8'hFF);
	endtask
	// Fill the transmit side until refused, then drain in order
	task automatic t_tx();
		logic [31:0] r;
		logic ok;
		for (int i = 0; i < 384; i++) i_mcu.wr_byte(i[7:0], ok);
		ahb(1'h0, ufh_pkg::A_STAT, 32'h0, r);
		chk(r[25:16], 10'h180);
		i_mcu.wr_byte(8'hEE, ok);
		chk(ok, 1'h0);
		for (int i = 0; i < 384; i++) begin
			ahb(1'h0, ufh_pkg::A_TXPOP, 32'h0, r);
			chk(r[8:0], {1'h1, i[7:0]});
		end
		ahb(1'h0, ufh_pkg::A_TXPOP, 32'h0, r);
		chk(r[8], 1'h0);
		chk(txnr_n, 1'h0);
	endtask
	// Overfill the receive side, then read back to back until empty
	task automatic t_rx();
		logic [31:0] r;
		logic [7:0] b;
		logic ok;
		for (int i = 0; i < 130; i++) wreg(ufh_pkg::A_RXPUSH, 32'h40 + i);
		ahb(1'h0, ufh_pkg::A_STAT, 32'h0, r);
		chk(r[7:0], 8'h80);
		chk(rxe_n, 1'h0);
		for (int i = 0; i < 128; i++) begin
			i_mcu.rd_byte(b, ok);
			chk(b, 8'h40 + i[7:0]);
		end
		i_mcu.rd_byte(b, ok);
		chk(ok, 1'h0);
	endtask
	// Bit-bang: two received bytes paced out, then back to FIFO mode
	task automatic t_bb();
		logic [31:0] r;
		int n;
		n = 0;
		wreg(ufh_pkg::A_RXPUSH, 32'h5A);
		wreg(ufh_pkg::A_RXPUSH, 32'hA5);
		wreg(ufh_pkg::A_BBDIR, 32'hFF);
		wreg(ufh_pkg::A_BBDIV, 32'h10);
		wreg(ufh_pkg::A_CTRL, 32'h10);
		for (int k = 0; k < 120; k++) begin
			@(posedge clk);
			if (bus.dout === 8'h5A && bus.doe_n === 8'h00) n++;
		end
		chk(n, 32'h11);
		chk({bus.doe_n, bus.dout}, 16'h00A5);
		chk(txnr_n, 1'h1);
		ahb(1'h0, ufh_pkg::A_STAT, 32'h0, r);
		chk(r[7:0], 8'h00);
		wreg(ufh_pkg::A_CTRL, 32'h00);
		repeat (2) @(posedge clk);
		chk(bus.doe_n, 8'hFF);
	endtask
	task automatic t_susp();
		logic res, snd, ok;
		i_mcu.wr_byte(8'h77, ok);
		wreg(ufh_pkg::A_CTRL, 32'h07);
		repeat (4) @(posedge clk);
		chk(pwr_n, 1'h1);
		chk(bus.pull_dn, 8'hFF);
		strobe(res, snd);
		chk({res, snd}, 2'h2);
		wreg(ufh_pkg::A_CTRL, 32'h02);
		repeat (4) @(posedge clk);
		chk(bus.pull_dn, 8'h00);
		strobe(res, snd);
		chk({res, snd}, 2'h1);
		wreg(ufh_pkg::A_CTRL, 32'h28);
		repeat (4) @(posedge clk);
		chk({send_now, iso}, 2'h1);
		wreg(ufh_pkg::A_CTRL, 32'h00);
	endtask
	// Flush timing at the shortest timeout, after ignored writes
	task automatic t_flush();
		logic [31:0] r;
		logic ok;
		int n;
		wreg(ufh_pkg::A_TOUT, 32'h0);
		wreg(ufh_pkg::A_BAUD, 32'h1234);
		ahb(1'h0, ufh_pkg::A_TOUT, 32'h0, r);
		chk(r, 32'h10);
		wreg(ufh_pkg::A_TOUT, 32'h1);
		i_mcu.wr_byte(8'h99, ok);
		n = 0;
		while (flush !== 1'h1 && n < 41000) begin
			@(posedge clk);
			n++;
		end
		chk(n > 39980 && n < 40020, 1'h1);
	endtask
	task automatic stop_test();
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		t_reset();
		t_tx();
		t_rx();
		t_bb();
		t_susp();
		t_flush();
		stop_test();
	end
	// Watchdog: about 1.7 times the expected run length of some 1.2 ms
	initial begin
		#2000000;
		failures++;
		stop_test();
	end
endmodule // ufh_port_tb_top
